/* File: tsp_pkg.sv */
// Purpose: shared constants for the timer channel serial port
// Assumes: 20 MHz system clock, plain register port, 32-bit data
// Notes:   offsets are byte addresses of aligned words
// How it works
// - every serviced state adds slot transition time
// - bit counter loads full 16-bit length
// - clock-only mode runs up to FFFF clocks
// - long receive keeps only last sampled bits
// - shift register data is never justified
// - 16-bit transfer replaces each outgoing bit
// - output on active edge, sample on opposite
// - service delay separates edge from data action
// - service request 11 starts; 00 idle
// - sequence bits select clock/transmit/receive mode
// - count to zero ends transfer, raises interrupt
// - direction bit: zero lsb first, one msb
package tsp_pkg;
  localparam int          CLK_HZ         = 20_000_000;
  localparam logic [7:0]  ADDR_CTRL      = 8'h00;
  localparam logic [7:0]  ADDR_HALF      = 8'h04;
  localparam logic [7:0]  ADDR_LEN       = 8'h08;
  localparam logic [7:0]  ADDR_DATA      = 8'h0C;
  localparam logic [7:0]  ADDR_STAT      = 8'h10;
  localparam logic [7:0]  ADDR_MASK      = 8'h14;
  localparam logic [7:0]  ADDR_BUSY      = 8'h18;
  // control word fields
  localparam int          CTRL_HSR_LSB   = 0;
  localparam int          CTRL_HSQ_LSB   = 2;
  localparam int          CTRL_DIR_BIT   = 4;
  localparam int          CTRL_POL_BIT   = 5;
  localparam int          CTRL_TB_LSB    = 8;
  localparam logic [1:0]  HSR_START      = 2'h3;
  localparam logic [1:0]  HSQ_CLK_ONLY   = 2'h0;
  localparam logic [1:0]  HSQ_TX         = 2'h1;
  localparam logic [1:0]  HSQ_RX         = 2'h2;
  localparam logic [1:0]  HSQ_FULL       = 2'h3;
  localparam logic [15:0] HALF_RESET     = 16'h0001;
  localparam logic [7:0]  TB_DIV_RESET   = 8'h00;
  // slot transition overhead in cpu clocks, shorter and longer form
  localparam int          SLOT_TST_SHORT = 10;
  localparam int          SLOT_TST_LONG  = 14;
  // service delay: slot transition plus one cycle of state work
  localparam logic [4:0]  SERVICE_DELAY  = 5'(SLOT_TST_SHORT + 1);
  localparam int          STAT_DONE_BIT  = 0;
endpackage

/* File: tsp_if.sv */
`timescale 1ns/1ps
// Purpose: carrier between the port top and the timebase divider
// Assumes: single system clock
// Notes:   divide ratio in, tick out
interface tsp_if;
  logic [7:0] div;
  logic       tick;
  modport core (output div, input tick);
  modport tb   (input div, output tick);
endinterface

/* File: tsp_timebase.sv */
`timescale 1ns/1ps
// Purpose: timebase counter producing a one-cycle tick
// Assumes: div is a plain register value
// Notes:   tick every div+1 system clocks
module tsp_timebase
  import tsp_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic nrst_i,
  tsp_if.tb         tb
);
  logic [7:0] cnt_q;
  logic [7:0] cnt_d;
  logic       tick_q;
  logic       tick_d;

  always_comb begin
    cnt_d  = cnt_q + 8'h01;
    tick_d = 1'b0;
    if (cnt_q >= tb.div) begin
      cnt_d  = 8'h00;
      tick_d = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      cnt_q  <= 8'h00;
      tick_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign tb.tick = tick_q;
endmodule

/* File: tsp_serial_port.sv */
`timescale 1ns/1ps
// Purpose: master-only timer serial port with register access
// Assumes: data in pin is asynchronous and synchronised here
// Notes:   data moves a fixed service delay after each clock edge
module tsp_serial_port
  import tsp_pkg::*;
(
  input  wire logic        SYS_CLK_I,
  input  wire logic        NRST_I,
  input  wire logic [7:0]  ADDR_I,
  input  wire logic [31:0] WDATA_I,
  input  wire logic        WR_I,
  input  wire logic        RD_I,
  output logic      [31:0] RDATA_O,
  output logic             SCLK_O,
  output logic             DOUT_O,
  output logic             DOUT_OE_O,
  input  wire logic        DIN_I,
  output logic             IRQ_O
);
  typedef enum {ST_IDLE, ST_RUN} tsp_state_e;

  tsp_if tbi ();
  tsp_timebase u_tb (
    .clk_i  (SYS_CLK_I),
    .nrst_i (NRST_I),
    .tb     (tbi)
  );

  tsp_state_e  state_q, state_d;
  logic [1:0]  hsq_q, hsq_d;
  logic        dir_q, dir_d;
  logic        pol_q, pol_d;
  logic [7:0]  div_q, div_d;
  logic [15:0] half_q, half_d;
  logic [15:0] len_q, len_d;
  logic [15:0] sr_q, sr_d;
  logic [15:0] bits_q, bits_d;
  logic [15:0] hcnt_q, hcnt_d;
  logic        clk_q, clk_d;
  logic        dout_q, dout_d;
  logic        oe_q, oe_d;
  logic [4:0]  dly_q, dly_d;
  logic        dly_lead_q, dly_lead_d;
  logic        stat_q, stat_d;
  logic        mask_q, mask_d;
  logic [31:0] rdata_q, rdata_d;
  logic        din_m_q, din_s_q;
  logic        done_ev;
  logic        start;
  logic        tx_en, rx_en;
  logic        out_bit, in_bit;

  assign tbi.div = div_q;

  // two-stage synchroniser for the data input pin
  always_ff @(posedge SYS_CLK_I) begin
    if (!NRST_I) begin
      din_m_q <= 1'b0;
      din_s_q <= 1'b0;
    end else begin
      din_m_q <= DIN_I;
      din_s_q <= din_m_q;
    end
  end

  assign start = WR_I && (ADDR_I == ADDR_CTRL) &&
                 (WDATA_I[CTRL_HSR_LSB +: 2] == HSR_START);
  assign tx_en = hsq_q[0];
  assign rx_en = hsq_q[1];
  assign out_bit = dir_q ? sr_q[15] : sr_q[0];
  assign in_bit  = rx_en ? din_s_q : 1'b0;

  // transfer engine
  always_comb begin
    state_d    = state_q;
    sr_d       = sr_q;
    bits_d     = bits_q;
    hcnt_d     = hcnt_q;
    clk_d      = clk_q;
    dout_d     = dout_q;
    oe_d       = oe_q;
    dly_d      = dly_q;
    dly_lead_d = dly_lead_q;
    done_ev    = 1'b0;
    if (WR_I && ADDR_I == ADDR_DATA && state_q == ST_IDLE) begin
      sr_d = WDATA_I[15:0];
    end
    case (state_q)
      ST_IDLE: begin
        clk_d = pol_q;
        if (start) begin
          bits_d  = WDATA_I[CTRL_HSQ_LSB +: 2] == HSQ_CLK_ONLY ?
                    len_q : len_q;
          hcnt_d  = 16'h0000;
          dly_d   = 5'h00;
          oe_d    = WDATA_I[CTRL_HSQ_LSB] && (len_q != 16'h0000);
          state_d = (len_q == 16'h0000) ? ST_IDLE : ST_RUN;
          done_ev = (len_q == 16'h0000);
        end
      end
      ST_RUN: begin
        if (dly_q != 5'h00) begin
          dly_d = dly_q - 5'h01;
          if (dly_q == 5'h01) begin
            if (dly_lead_q) begin
              // leading edge serviced: present next bit
              if (tx_en) begin
                dout_d = out_bit;
              end
            end else begin
              // trailing edge serviced: sample and shift
              if (dir_q) begin
                sr_d = {sr_q[14:0], in_bit};
              end else begin
                sr_d = {in_bit, sr_q[15:1]};
              end
              bits_d = bits_q - 16'h0001;
              if (bits_q == 16'h0001) begin
                state_d = ST_IDLE;
                done_ev = 1'b1;
                clk_d   = pol_q;
                oe_d    = 1'b0;
              end
            end
          end
        end
        if (tbi.tick && state_d == ST_RUN) begin
          if (hcnt_q + 16'h0001 >= half_q) begin
            hcnt_d     = 16'h0000;
            clk_d      = ~clk_q;
            dly_d      = SERVICE_DELAY;
            dly_lead_d = (clk_q == pol_q);
          end else begin
            hcnt_d = hcnt_q + 16'h0001;
          end
        end
      end
      default: state_d = ST_IDLE;
    endcase
  end

  // register port and interrupt
  always_comb begin
    hsq_d   = hsq_q;
    dir_d   = dir_q;
    pol_d   = pol_q;
    div_d   = div_q;
    half_d  = half_q;
    len_d   = len_q;
    mask_d  = mask_q;
    stat_d  = stat_q;
    rdata_d = 32'h0000_0000;
    if (WR_I) begin
      if (ADDR_I == ADDR_CTRL) begin
        hsq_d = WDATA_I[CTRL_HSQ_LSB +: 2];
        dir_d = WDATA_I[CTRL_DIR_BIT];
        pol_d = WDATA_I[CTRL_POL_BIT];
        div_d = WDATA_I[CTRL_TB_LSB +: 8];
      end else if (ADDR_I == ADDR_HALF) begin
        half_d = WDATA_I[15:0];
      end else if (ADDR_I == ADDR_LEN) begin
        len_d = WDATA_I[15:0];
      end else if (ADDR_I == ADDR_STAT) begin
        if (WDATA_I[STAT_DONE_BIT]) begin
          stat_d = 1'b0;
        end
      end else if (ADDR_I == ADDR_MASK) begin
        mask_d = WDATA_I[STAT_DONE_BIT];
      end
    end
    if (done_ev) begin
      stat_d = 1'b1;
    end
    if (RD_I) begin
      if (ADDR_I == ADDR_CTRL) begin
        rdata_d = {16'h0000, div_q, 2'h0, pol_q, dir_q, hsq_q, 2'h0};
      end else if (ADDR_I == ADDR_HALF) begin
        rdata_d = {16'h0000, half_q};
      end else if (ADDR_I == ADDR_LEN) begin
        rdata_d = {16'h0000, len_q};
      end else if (ADDR_I == ADDR_DATA) begin
        rdata_d = {16'h0000, sr_q};
      end else if (ADDR_I == ADDR_STAT) begin
        rdata_d = {31'h0000_0000, stat_q};
      end else if (ADDR_I == ADDR_MASK) begin
        rdata_d = {31'h0000_0000, mask_q};
      end else if (ADDR_I == ADDR_BUSY) begin
        rdata_d = {bits_q, 15'h0000, state_q == ST_RUN};
      end else begin
        rdata_d = 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (!NRST_I) begin
      state_q    <= ST_IDLE;
      sr_q       <= 16'h0000;
      bits_q     <= 16'h0000;
      hcnt_q     <= 16'h0000;
      clk_q      <= 1'b0;
      dout_q     <= 1'b0;
      oe_q       <= 1'b0;
      dly_q      <= 5'h00;
      dly_lead_q <= 1'b0;
      hsq_q      <= HSQ_CLK_ONLY;
      dir_q      <= 1'b0;
      pol_q      <= 1'b0;
      div_q      <= TB_DIV_RESET;
      half_q     <= HALF_RESET;
      len_q      <= 16'h0000;
      stat_q     <= 1'b0;
      mask_q     <= 1'b0;
      rdata_q    <= 32'h0000_0000;
    end else begin
      state_q    <= state_d;
      sr_q       <= sr_d;
      bits_q     <= bits_d;
      hcnt_q     <= hcnt_d;
      clk_q      <= clk_d;
      dout_q     <= dout_d;
      oe_q       <= oe_d;
      dly_q      <= dly_d;
      dly_lead_q <= dly_lead_d;
      hsq_q      <= hsq_d;
      dir_q      <= dir_d;
      pol_q      <= pol_d;
      div_q      <= div_d;
      half_q     <= half_d;
      len_q      <= len_d;
      stat_q     <= stat_d;
      mask_q     <= mask_d;
      rdata_q    <= rdata_d;
    end
  end

  assign RDATA_O   = rdata_q;
  assign SCLK_O    = clk_q;
  assign DOUT_O    = dout_q;
  assign DOUT_OE_O = oe_q;
  assign IRQ_O     = stat_q & mask_q;

  property p_idle_clock;
    @(posedge SYS_CLK_I) disable iff (!NRST_I)
      (state_q == ST_IDLE && !start) |=> (SCLK_O == $past(pol_q));
  endproperty
  a_idle_clock: assert property (p_idle_clock)
    else $error("clock not at idle level");

  property p_load_len;
    @(posedge SYS_CLK_I) disable iff (!NRST_I)
      (state_q == ST_IDLE && start && len_q != 16'h0000)
      |=> (bits_q == $past(len_q) && state_q == ST_RUN);
  endproperty
  a_load_len: assert property (p_load_len)
    else $error("bit count not loaded from length");

  property p_done_irq;
    @(posedge SYS_CLK_I) disable iff (!NRST_I)
      (state_q == ST_RUN && state_d == ST_IDLE) |=> stat_q;
  endproperty
  a_done_irq: assert property (p_done_irq)
    else $error("done flag not set at end");

  property p_irq_gate;
    @(posedge SYS_CLK_I) disable iff (!NRST_I)
      (done_ev && mask_d) |=> IRQ_O;
  endproperty
  a_irq_gate: assert property (p_irq_gate)
    else $error("interrupt not gated by mask");

  property p_delay;
    @(posedge SYS_CLK_I) disable iff (!NRST_I)
      (state_q == ST_RUN && $changed(SCLK_O) && state_d == ST_RUN)
      |-> dly_q == SERVICE_DELAY ##1 dly_q == SERVICE_DELAY - 5'h01;
  endproperty
  a_delay: assert property (p_delay)
    else $error("service delay not started at edge");

  property p_rx_oe;
    @(posedge SYS_CLK_I) disable iff (!NRST_I)
      (state_q == ST_RUN && !tx_en) |-> !DOUT_OE_O;
  endproperty
  a_rx_oe: assert property (p_rx_oe)
    else $error("output driven without transmit");

  property p_oe_idle;
    @(posedge SYS_CLK_I) disable iff (!NRST_I)
      (state_q == ST_IDLE && !start) |=> !DOUT_OE_O;
  endproperty
  a_oe_idle: assert property (p_oe_idle)
    else $error("output driven while idle");

  property p_shift_right;
    @(posedge SYS_CLK_I) disable iff (!NRST_I)
      (state_q == ST_RUN && dly_q == 5'h01 && !dly_lead_q && !dir_q)
      |=> sr_q[14:0] == $past(sr_q[15:1]);
  endproperty
  a_shift_right: assert property (p_shift_right)
    else $error("lsb-first shift wrong");

  property p_shift_left;
    @(posedge SYS_CLK_I) disable iff (!NRST_I)
      (state_q == ST_RUN && dly_q == 5'h01 && !dly_lead_q && dir_q)
      |=> sr_q[15:1] == $past(sr_q[14:0]);
  endproperty
  a_shift_left: assert property (p_shift_left)
    else $error("msb-first shift wrong");
endmodule

/* File: tsp_peer_model.sv */
// Purpose: behavioural serial peripheral on the far side of the port
// Assumes: serial clock is seen in the system clock domain
// Notes:   data in toggles every cycle once its hold time runs out
`timescale 1ns/1ps
module tsp_peer_model #(
  parameter int HOLD = 16
) (
  input  wire logic        clk_i,
  input  wire logic        nrst_i,
  input  wire logic        sclk_i,
  input  wire logic        pol_i,
  input  wire logic        dout_i,
  input  wire logic        ld_i,
  input  wire logic [31:0] pat_i,
  output logic             din_o,
  output logic      [31:0] cap_o
);
  logic        prev_q;
  logic        armed_q;
  logic [31:0] pat_q;
  int          hold_q;
  always @(posedge clk_i) begin
    prev_q <= sclk_i;
    if (!nrst_i) begin
      armed_q <= 1'b1;
      hold_q <= 0;
      din_o <= 1'b0;
      cap_o <= '0;
    end else if (ld_i) begin
      pat_q <= pat_i;
      cap_o <= '0;
    end else if (sclk_i != prev_q && sclk_i != pol_i) begin
      // leading edge: next bit, held until past the trailing sample
      din_o <= pat_q[0];
      pat_q <= {pat_q[0], pat_q[31:1]};
      armed_q <= 1'b0;
    end else if (sclk_i != prev_q) begin
      cap_o <= {cap_o[30:0], dout_i};
      armed_q <= 1'b1;
      hold_q <= 0;
    end else if (armed_q && hold_q < HOLD) begin
      hold_q <= hold_q + 1;
    end else if (armed_q) begin
      din_o <= ~din_o;
    end
  end
endmodule

/* File: testbench.sv */
// Purpose: self-checking bench for the timer serial port
// Assumes: divide 3 and half-period 5 give 20 clocks per half
// Notes:   random transfers mixed with fixed corner cases
`timescale 1ns/1ps
module testbench
  import tsp_pkg::*;
;
  logic        clk;
  logic        nrst;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic        wr;
  logic        rd;
  logic [31:0] rdata;
  logic        sclk, dout, dout_oe, din, irq, ld, pol;
  logic        sclk_p, oe_p, dout_p;
  logic [31:0] pat, cap;
  int          errors = 0, checks_done = 0, edges = 0, oe_n = 0, since = 0;
  integer      seed = 32'hbf46;
  logic [7:0]  ra [8] = '{ADDR_CTRL, ADDR_HALF, ADDR_LEN, ADDR_DATA,
                          ADDR_STAT, ADDR_MASK, ADDR_BUSY, 8'h1C};

  tsp_serial_port dut (.SYS_CLK_I(clk), .NRST_I(nrst), .ADDR_I(addr),
    .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .SCLK_O(sclk),
    .DOUT_O(dout), .DOUT_OE_O(dout_oe), .DIN_I(din), .IRQ_O(irq));
  tsp_peer_model peer (.clk_i(clk), .nrst_i(nrst), .sclk_i(sclk),
    .pol_i(pol), .dout_i(dout), .ld_i(ld), .pat_i(pat), .din_o(din),
    .cap_o(cap));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // serial clock edges, drive cycles and data-out timing after an edge
  always @(posedge clk) begin
    sclk_p <= sclk;
    oe_p <= dout_oe;
    dout_p <= dout;
    since <= (sclk !== sclk_p) ? 0 : since + 1;
    if (sclk !== sclk_p) edges <= edges + 1;
    if (dout_oe) oe_n <= oe_n + 1;
    if (oe_p && dout_oe && dout !== dout_p)
      chk(32'(since >= SERVICE_DELAY - 2 && since <= SERVICE_DELAY + 2), 1);
  end

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic chk_rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] v;
    rd_reg(a, v);
    chk(v, exp);
  endtask

  function automatic logic [47:0] expect_xfer(input logic [1:0] m,
    input logic dir, input int len, input logic [15:0] d,
    input logic [31:0] pw);
    logic        ib;
    logic [31:0] c;
    c = '0;
    for (int i = 0; i < len; i++) begin
      c = {c[30:0], dir ? d[15] : d[0]};
      ib = m[1] ? pw[i % 32] : 1'b0;
      d = dir ? {d[14:0], ib} : {ib, d[15:1]};
    end
    return {c, d};
  endfunction

  task automatic xfer(input logic [1:0] m, input logic dir, input logic p,
    input int len, input logic [15:0] d, input logic [31:0] pw,
    input logic msk);
    logic [31:0] ctl, v, mk;
    logic [47:0] ex;
    int          e0, o0;
    ex = expect_xfer(m, dir, len, d, pw);
    mk = (len >= 32) ? '1 : (32'h1 << len) - 32'h1;
    ctl = {16'h0, 8'h03, 2'h0, p, dir, m, 2'h1};
    wr_reg(ADDR_HALF, 32'h5);
    wr_reg(ADDR_LEN, 32'(len));
    wr_reg(ADDR_DATA, {16'h0, d});
    wr_reg(ADDR_MASK, {31'h0, msk});
    wr_reg(ADDR_CTRL, ctl);
    wr_reg(ADDR_CTRL, ctl ^ 32'h3);
    @(posedge clk);
    pol <= p;
    pat <= pw;
    ld <= 1'b1;
    @(posedge clk);
    ld <= 1'b0;
    e0 = edges;
    o0 = oe_n;
    chk_rd(ADDR_BUSY, 0);
    wr_reg(ADDR_CTRL, ctl | 32'h3);
    for (int i = 0; i < 2000; i++) begin
      rd_reg(ADDR_BUSY, v);
      if (v[0] === 1'b0) break;
    end
    chk(32'(v[0]), 0);
    repeat (2) @(posedge clk);
    chk(32'(edges - e0), 32'(2 * len));
    chk(32'(sclk), 32'(p));
    chk(32'(dout_oe), 0);
    if (m != HSQ_CLK_ONLY)
      chk_rd(ADDR_DATA, {16'h0, ex[15:0]});
    if (m[0])
      chk(cap & mk, ex[47:16] & mk);
    else
      chk(32'(oe_n - o0), 0);
    chk_rd(ADDR_STAT, 1);
    chk(32'(irq), 32'(msk));
    if (!msk) begin
      wr_reg(ADDR_MASK, 32'h1);
      repeat (2) @(posedge clk);
      chk(32'(irq), 1);
    end
    wr_reg(ADDR_STAT, 32'h1);
    repeat (2) @(posedge clk);
    chk(32'(irq), 0);
    chk_rd(ADDR_STAT, 0);
  endtask

  task automatic tally_and_finish;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    tally_and_finish;
  end

  initial begin
    nrst = 1'b0;
    addr = 8'h00;
    wdata = 32'h0;
    wr = 1'b0;
    rd = 1'b0;
    ld = 1'b0;
    pol = 1'b0;
    pat = 32'h0;
    repeat (10) @(posedge clk);
    chk(32'(sclk), 0);
    chk(32'(irq), 0);
    nrst <= 1'b1;
    wr_reg(8'h1C, 32'hFFFF_FFFF);
    foreach (ra[i])
      chk_rd(ra[i], (i == 1) ? {16'h0, HALF_RESET} : 32'h0);
    xfer(HSQ_FULL, 1'b1, 1'b0, 16, 16'hA5C3, 32'h9AC3_57E1, 1'b1);
    xfer(HSQ_FULL, 1'b0, 1'b1, 8, 16'h3C96, 32'h0F1E_2D4B, 1'b1);
    xfer(HSQ_TX, 1'b0, 1'b0, 10, 16'h8E71, 32'hFFFF_0000, 1'b1);
    xfer(HSQ_RX, 1'b1, 1'b1, 5, 16'h4D2B, 32'h1234_ABCD, 1'b0);
    xfer(HSQ_CLK_ONLY, 1'b0, 1'b1, 40, 16'h0000, 32'h0, 1'b1);
    xfer(HSQ_FULL, 1'b0, 1'b0, 20, 16'hC3A5, 32'h6B2D_9E47, 1'b1);
    xfer(HSQ_TX, 1'b1, 1'b0, 0, 16'h7777, 32'h0, 1'b1);
    // reset in the middle of a transfer returns everything to idle
    wr_reg(ADDR_LEN, 32'h10);
    wr_reg(ADDR_CTRL, 32'h0000_030F);
    repeat (100) @(posedge clk);
    nrst <= 1'b0;
    repeat (3) @(posedge clk);
    chk(32'(sclk), 0);
    chk(32'(dout_oe), 0);
    chk(32'(irq), 0);
    nrst <= 1'b1;
    chk_rd(ADDR_BUSY, 0);
    chk_rd(ADDR_CTRL, 0);
    repeat (4)
      xfer(2'($random(seed)), 1'($random(seed)), 1'($random(seed)),
           1 + int'({$random(seed)} % 16), 16'($random(seed)),
           $random(seed), 1'b1);
    tally_and_finish;
  end
endmodule
